// *** src/pdwd_ctrl.sv ***
// power-down entry, wake-up sequencing and watchdog timer with apb registers
// assumes core strobes, pins and oscillator tick are synchronous to pclk
// Overview of operation
// RULE1 - only the halt instruction enters power-down; core stops, oscillator stops
// RULE2 - registers and port states hold unchanged while powered down
// RULE3 - on halt, oscillator-sourced watchdog clears and runs; instruction-sourced stops
// RULE4 - halt sets sleep_flag and clears expiry_flag
// RULE5 - wake on external reset, port A falling edge, interrupt or watchdog overflow
// RULE6 - external reset wake gives full reset; watchdog wake gives watchdog reset; a watchdog wake here pulses pc_sp_reset, not wdt_reset
// RULE7 - sleep_flag cleared by power-up or watchdog clears, set by halt
// RULE8 - expiry_flag set on time-out; sleep time-out resets only pc and stack
// RULE9 - each port A pin has own wake enable; resume after halt
// RULE10 - disabled interrupt or full stack resumes after halt, interrupt stays pending
// RULE11 - enabled interrupt with free stack takes normal interrupt response
// RULE12 - interrupt already pending at halt cannot wake the device
// RULE13 - wait 1024 system clocks after wake; isr starts at least a cycle later
// RULE14 - watchdog clock is its own oscillator or system clock divided by 4
// RULE15 - watchdog disabled makes all watchdog instructions no-operations
// RULE16 - oscillator source passes an 8-stage divide-by-256 counter first
// RULE17 - bits 0 to 2 of prescale register select ratio, all ones 1:128
// RULE18 - instruction-clock watchdog stops in power-down and cannot wake
// RULE19 - running time-out resets device and sets expiry_flag; sleeping one pc/stack only
// RULE20 - counter and prescaler cleared by reset pin low, clear instructions, halt
// RULE21 - option picks single clear instruction or the two-instruction pair
// RULE22 - repeating the same half of the pair does nothing
// RULE23 - select value n gives division ratio 2 to the n
`timescale 1ns/100ps
module pdwd_ctrl
	import pdwd_pkg::*;
#(
	parameter int PA_W = 8,
	parameter int INT_W = 4
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pdwd_cfg_t cfg,
	input wire pdwd_instr_t instr,
	input wire logic wdt_osc_tick,
	input wire logic external_init_pin_n,
	input wire logic [PA_W-1:0] port_a_pins,
	input wire logic [INT_W-1:0] int_req,
	input wire logic [INT_W-1:0] int_en,
	input wire logic stack_full,
	output logic osc_run,
	output logic core_hold,
	output logic resume_next,
	output logic isr_go,
	output logic full_reset,
	output logic wdt_reset,
	output logic pc_sp_reset
);
	// elaboration check on widths the logic serves
	if (PA_W < 1 || PA_W > 8 || INT_W < 1)
		$error("pdwd_ctrl: unsupported PA_W or INT_W");

	localparam logic [10:0] WAIT_LAST = 11'(PDWD_WAKE_CYC - 1);
	localparam logic [1:0] DIV4_LAST = 2'(PDWD_INSTR_DIV - 1);
	localparam logic [7:0] OSC_LAST = 8'(PDWD_OSC_DIV - 1);
	localparam logic [2:0] ISR_LAST = 3'(PDWD_ISR_EXTRA_CYC - 1);
	localparam logic [1:0] HALF_NONE = 2'h0;
	localparam logic [1:0] HALF_FIRST = 2'h1;
	localparam logic [1:0] HALF_SECOND = 2'h2;

	pdwd_state_t st_q;
	pdwd_cause_t cause_q;
	logic [7:0] prescale_q;
	logic sleep_flag_q;
	logic expiry_flag_q;
	logic [1:0] div4_q;
	logic [7:0] osc_pre_q;
	logic [PDWD_PRE_W-1:0] watchdog_counter_q;
	logic [1:0] last_half_q;
	logic [10:0] wait_cnt_q;
	logic [2:0] isr_cnt_q;
	logic [INT_W-1:0] armed_q;
	logic [INT_W-1:0] woke_int_q;
	logic [PA_W-1:0] pa_prev_q;
	logic instr_tick;
	logic osc_tick256;
	logic base_tick;
	logic halt_take;
	logic clr_ok;
	logic wdt_clear;
	logic timeout;
	logic pa_fall;
	logic int_wake;
	logic wake;
	logic wait_done;
	logic bus_wr;
	logic sel_prescale;
	logic sel_status;
	logic sel_count;

	// last count value for a select n: ratio is 2 to the n
	function automatic logic [PDWD_PRE_W-1:0] ratio_last(input logic [2:0] sel);
		logic [PDWD_PRE_W:0] r;
		r = (PDWD_PRE_W+1)'(1) << sel; // RULE23
		return PDWD_PRE_W'(r - (PDWD_PRE_W+1)'(1));
	endfunction

	// core stops on halt; only a wake sequence lets it run again
	assign osc_run = (st_q != ST_SLEEP); // RULE1
	assign core_hold = (st_q != ST_RUN); // RULE2
	assign halt_take = instr.halt && (st_q == ST_RUN); // RULE1

	// instruction clock divider freezes with the system oscillator
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div4_q <= 2'h0;
		else if (osc_run) // RULE2
			div4_q <= div4_q + 2'h1;
	end
	assign instr_tick = osc_run && (div4_q == DIV4_LAST); // RULE14 RULE18

	// 8-stage divider behind the watchdog oscillator, cleared with the prescaler
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			osc_pre_q <= 8'h00;
		else if (wdt_clear)
			osc_pre_q <= 8'h00; // RULE20
		else if (wdt_osc_tick)
			osc_pre_q <= osc_pre_q + 8'h01; // RULE16
	end
	assign osc_tick256 = wdt_osc_tick && (osc_pre_q == OSC_LAST); // RULE16
	assign base_tick = cfg.src_osc ? osc_tick256 : instr_tick; // RULE14 RULE3

	// two-instruction scheme remembers the half last executed
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			last_half_q <= HALF_NONE;
		else if (cfg.wdt_enable && cfg.two_clear && st_q == ST_RUN)
		begin
			if (instr.clr_first)
				last_half_q <= HALF_FIRST;
			else if (instr.clr_second)
				last_half_q <= HALF_SECOND;
		end
	end

	// a clear counts only when the other half follows; repeats are ignored
	always_comb
	begin
		clr_ok = 1'b0;
		if (cfg.wdt_enable && st_q == ST_RUN) // RULE15
		begin
			if (!cfg.two_clear)
				clr_ok = instr.clr_single; // RULE21
			else
				clr_ok = (instr.clr_first && last_half_q == HALF_SECOND)
					|| (instr.clr_second && last_half_q == HALF_FIRST); // RULE21 RULE22
		end
	end
	assign wdt_clear = !external_init_pin_n || clr_ok || halt_take; // RULE20 RULE3

	// watchdog counter; time-out when the selected ratio is reached
	assign timeout = cfg.wdt_enable && base_tick && !wdt_clear
		&& (watchdog_counter_q == ratio_last(prescale_q[PDWD_SEL_MSB:PDWD_SEL_LSB])); // RULE17
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			watchdog_counter_q <= '0;
		else if (wdt_clear || timeout)
			watchdog_counter_q <= '0; // RULE20
		else if (cfg.wdt_enable && base_tick)
			watchdog_counter_q <= watchdog_counter_q + PDWD_PRE_W'(1);
	end

	// wake sources; a request already pending at halt is not armed
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			armed_q <= '0;
		else if (halt_take)
			armed_q <= ~int_req; // RULE12
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pa_prev_q <= '1;
		else
			pa_prev_q <= port_a_pins;
	end
	assign pa_fall = |(pa_prev_q & ~port_a_pins & cfg.pa_wake_en[PA_W-1:0]); // RULE9
	assign int_wake = |(int_req & armed_q); // RULE12
	assign wake = (st_q == ST_SLEEP)
		&& (!external_init_pin_n || timeout || pa_fall || int_wake); // RULE5
	assign wait_done = (st_q == ST_WAIT) && (wait_cnt_q == WAIT_LAST);

	// sequencer: sleep, fixed wake wait, optional isr delay
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_q <= ST_RUN;
		else
		begin
			unique case (st_q)
				ST_RUN:
					if (halt_take)
						st_q <= ST_SLEEP; // RULE1
				ST_SLEEP:
					if (wake)
						st_q <= ST_WAIT; // RULE5
				ST_WAIT:
					if (wait_done)
						st_q <= (cause_q == WK_INT && |(woke_int_q & int_en) && !stack_full)
							? ST_ISR : ST_RUN; // RULE11 RULE10
				ST_ISR:
					if (isr_cnt_q == ISR_LAST)
						st_q <= ST_RUN; // RULE13
			endcase
		end
	end

	// cause of the wake, by priority: reset pin, watchdog, port, interrupt
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cause_q <= WK_EXT;
			woke_int_q <= '0;
		end
		else if (wake)
		begin
			woke_int_q <= int_req & armed_q;
			if (!external_init_pin_n)
				cause_q <= WK_EXT; // RULE6
			else if (timeout)
				cause_q <= WK_WDT; // RULE6
			else if (pa_fall)
				cause_q <= WK_PORT; // RULE9
			else
				cause_q <= WK_INT;
		end
	end

	// wait counters for the wake delay and the isr lag
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wait_cnt_q <= 11'h000;
			isr_cnt_q <= 3'h0;
		end
		else
		begin
			wait_cnt_q <= (st_q == ST_WAIT) ? wait_cnt_q + 11'h001 : 11'h000; // RULE13
			isr_cnt_q <= (st_q == ST_ISR) ? isr_cnt_q + 3'h1 : 3'h0;
		end
	end

	// one-cycle reset and resume strobes to the core, registered
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			resume_next <= 1'b0;
			isr_go <= 1'b0;
			full_reset <= 1'b0;
			pc_sp_reset <= 1'b0;
			wdt_reset <= 1'b0;
		end
		else
		begin
			resume_next <= wait_done && (cause_q == WK_PORT
				|| (cause_q == WK_INT && st_q == ST_WAIT
				&& !(|(woke_int_q & int_en) && !stack_full))); // RULE9 RULE10 RULE13
			isr_go <= (st_q == ST_ISR) && (isr_cnt_q == ISR_LAST); // RULE11 RULE13
			full_reset <= wait_done && cause_q == WK_EXT; // RULE6
			pc_sp_reset <= wait_done && cause_q == WK_WDT; // RULE8 RULE19
			wdt_reset <= timeout && st_q == ST_RUN; // RULE19
		end
	end

	// status flags: hardware set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sleep_flag_q <= 1'b0; // RULE7
			expiry_flag_q <= 1'b0;
		end
		else
		begin
			if (halt_take)
				sleep_flag_q <= 1'b1; // RULE4 RULE7
			else if (clr_ok)
				sleep_flag_q <= 1'b0; // RULE7
			if (timeout)
				expiry_flag_q <= 1'b1; // RULE8 RULE19
			else if (halt_take)
				expiry_flag_q <= 1'b0; // RULE4
		end
	end

	// apb slave: zero wait states, unmapped offsets answer an error
	assign pready = 1'b1;
	assign sel_prescale = (paddr == PDWD_OFS_PRESCALE);
	assign sel_status = (paddr == PDWD_OFS_STATUS);
	assign sel_count = (paddr == PDWD_OFS_COUNT);
	assign bus_wr = psel && penable && pwrite && sel_prescale;
	assign pslverr = psel && penable && !(sel_prescale || sel_status || sel_count);

	// prescale register returns to its default on a running time-out or reset pin
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prescale_q <= PDWD_PRESCALE_RST;
		else if ((timeout && st_q == ST_RUN) || !external_init_pin_n)
			prescale_q <= PDWD_PRESCALE_RST; // RULE19
		else if (bus_wr)
			prescale_q <= pwdata[7:0]; // RULE17
	end

	// read data registered in the setup phase, valid during access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable)
		begin
			prdata <= 32'h0000_0000;
			if (sel_prescale)
				prdata[7:0] <= prescale_q;
			else if (sel_status)
			begin
				prdata[PDWD_STAT_SLEEP] <= sleep_flag_q;
				prdata[PDWD_STAT_EXPIRY] <= expiry_flag_q;
				prdata[PDWD_STAT_STATE +: 2] <= st_q;
			end
			else if (sel_count)
				prdata[PDWD_PRE_W-1:0] <= watchdog_counter_q;
		end
	end

	// checks on the block's own behaviour
	int unsigned wait_len_q;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			wait_len_q <= 0;
		else
			wait_len_q <= (st_q == ST_WAIT) ? wait_len_q + 1 : 0;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_halt_enters: assert property (halt_take |=> st_q == ST_SLEEP && !osc_run) // RULE1
		else $error("halt did not stop the oscillator");
	a_halt_flags: assert property (halt_take |=> sleep_flag_q && !expiry_flag_q) // RULE4
		else $error("halt flags wrong");
	a_halt_clears: assert property (halt_take |=> watchdog_counter_q == '0) // RULE3
		else $error("halt did not clear watchdog");
	a_wait_length: assert property ($fell(st_q == ST_WAIT) |-> wait_len_q == PDWD_WAKE_CYC) // RULE13
		else $error("wake wait not 1024 cycles");
	a_isr_later: assert property (isr_go |-> $past(st_q, 2) == ST_ISR && !resume_next) // RULE13
		else $error("isr started too early");
	a_instr_stop: assert property (!cfg.src_osc && st_q == ST_SLEEP |-> !base_tick) // RULE18
		else $error("instruction clock ran in sleep");
	a_off_quiet: assert property (!cfg.wdt_enable |=> !wdt_reset && !$rose(st_q == ST_WAIT && cause_q == WK_WDT)) // RULE15
		else $error("disabled watchdog acted");
	a_run_timeout: assert property (timeout && st_q == ST_RUN
		|=> wdt_reset && expiry_flag_q && prescale_q == PDWD_PRESCALE_RST) // RULE19
		else $error("running time-out handled wrong");
	a_sleep_timeout: assert property (timeout && st_q == ST_SLEEP
		|=> st_q == ST_WAIT && expiry_flag_q && sleep_flag_q && !wdt_reset) // RULE8
		else $error("sleep time-out handled wrong");
	a_pending_blocked: assert property (st_q == ST_SLEEP && external_init_pin_n && !pa_fall
		&& !timeout && (int_req & armed_q) == '0 |=> st_q == ST_SLEEP) // RULE12
		else $error("woke without an armed source");

	c_wdt_wake: cover property (st_q == ST_WAIT && cause_q == WK_WDT ##1 1'b1);
	c_isr_path: cover property (isr_go);
	c_port_wake: cover property (resume_next && cause_q == WK_PORT);
	c_pair_clear: cover property (cfg.two_clear && clr_ok);
endmodule

// *** src/pdwd_pkg.sv ***
// constants, register map and carrier types for the power-down / watchdog block
// assumes a single 125 MHz clock that is also the system clock of the core
package pdwd_pkg;
	// register byte offsets on the apb bus
	localparam logic [7:0] PDWD_OFS_PRESCALE = 8'h00;
	localparam logic [7:0] PDWD_OFS_STATUS = 8'h04;
	localparam logic [7:0] PDWD_OFS_COUNT = 8'h08;
	// field positions and reset values
	localparam int PDWD_SEL_LSB = 0;
	localparam int PDWD_SEL_MSB = 2;
	localparam int PDWD_STAT_SLEEP = 0;
	localparam int PDWD_STAT_EXPIRY = 1;
	localparam int PDWD_STAT_STATE = 2;
	localparam logic [7:0] PDWD_PRESCALE_RST = 8'h07;
	// timing
	localparam int PDWD_CLK_MHZ = 125;
	localparam int PDWD_SYS_PER_PCLK = 1; // system clock periods per pclk cycle
	localparam int PDWD_WAKE_PERIODS = 1024; // system clock periods after wake
	localparam int PDWD_WAKE_CYC = PDWD_WAKE_PERIODS / PDWD_SYS_PER_PCLK;
	localparam int PDWD_INSTR_DIV = 4; // instruction clock = system clock / 4
	localparam int PDWD_ISR_EXTRA_CYC = PDWD_INSTR_DIV; // extra delay before isr
	localparam int PDWD_OSC_DIV = 256; // 8-stage divider on the watchdog oscillator
	localparam int PDWD_PRE_W = 7; // prescaler reaches 1:128
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_SLEEP = 2'b01,
		ST_WAIT = 2'b10,
		ST_ISR = 2'b11
	} pdwd_state_t;
	typedef enum logic [1:0] {
		WK_EXT = 2'b00,
		WK_WDT = 2'b01,
		WK_PORT = 2'b10,
		WK_INT = 2'b11
	} pdwd_cause_t;
	// fixed configuration options, set at programming time
	typedef struct packed {
		logic wdt_enable;
		logic src_osc;
		logic two_clear;
		logic [7:0] pa_wake_en;
	} pdwd_cfg_t;
	// one-cycle instruction strobes from the core
	typedef struct packed {
		logic halt;
		logic clr_single;
		logic clr_first;
		logic clr_second;
	} pdwd_instr_t;
endpackage

// *** test/pdwd_core_model.sv ***
// core model: turns bench requests into one-cycle instruction strobes
// assumes requests are single-cycle pulses on go, synchronous to pclk
`timescale 1ns/100ps
module pdwd_core_model
	import pdwd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic core_hold,
	input wire logic go,
	input wire logic [1:0] op,
	output pdwd_instr_t instr
);
	// a held core executes nothing, so requests made while asleep are dropped
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			instr <= '0;
		else
		begin
			instr <= '0;
			if (go && !core_hold)
				instr <= pdwd_instr_t'(4'b1000 >> op);
		end
	end
endmodule

// *** test/power_down_wakeup_watchdog_tb.sv ***
// self-checking bench for the power-down and watchdog controller
// assumes pdwd_pkg and the core model are compiled first
`timescale 1ns/100ps
module power_down_wakeup_watchdog_tb;
	import pdwd_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, osc_run, core_hold;
	logic resume_next, isr_go, full_reset, wdt_reset, pc_sp_reset;
	pdwd_cfg_t cfg = '{1'b1, 1'b0, 1'b0, 8'h01};
	pdwd_instr_t instr;
	logic tick = 1'b0;
	logic tick_on = 1'b0;
	logic ext_n = 1'b1;
	logic [7:0] pins = 8'hff;
	logic [3:0] int_req = 4'h0;
	logic [3:0] int_en = 4'h0;
	logic stack_full = 1'b0;
	logic go = 1'b0;
	logic [1:0] op = 2'd0;
	logic [4:0] ev;
	logic [31:0] rd;
	logic err;
	int n;
	int comparisons = 0;
	int miscompares = 0;

	// wake and reset pulses gathered for the bounded wait and quiet tasks
	assign ev = {wdt_reset, full_reset, pc_sp_reset, isr_go, resume_next};

	always #4 pclk = ~pclk;

	// oscillator tick every other cycle, only while enabled
	always @(posedge pclk)
		tick <= tick_on & ~tick;

	pdwd_ctrl #(.PA_W(8), .INT_W(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg(cfg), .instr(instr),
		.wdt_osc_tick(tick), .external_init_pin_n(ext_n), .port_a_pins(pins),
		.int_req(int_req), .int_en(int_en), .stack_full(stack_full), .osc_run(osc_run),
		.core_hold(core_hold), .resume_next(resume_next), .isr_go(isr_go),
		.full_reset(full_reset), .wdt_reset(wdt_reset), .pc_sp_reset(pc_sp_reset));

	pdwd_core_model core (.pclk(pclk), .presetn(presetn), .core_hold(core_hold),
		.go(go), .op(op), .instr(instr));

	task automatic finish_test();
		if (miscompares == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer; pready is awaited under a bound, never assumed
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20)
		begin
			miscompares++;
			finish_test();
		end
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask

	// ask the core model for one instruction and let it land
	task automatic ins(input logic [1:0] o);
		@(posedge pclk);
		op <= o;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask

	// n = cycles until the chosen pulse; running out of the bound ends the run
	task automatic wait_ev(input int k, input int lim);
		for (n = 1; n <= lim; n++)
		begin
			@(posedge pclk);
			if (ev[k] === 1'b1)
				return;
		end
		miscompares++;
		finish_test();
	endtask

	task automatic quiet(input int lim);
		logic [4:0] s;
		s = 5'h00;
		repeat (lim)
		begin
			@(posedge pclk);
			s = s | ev;
		end
		chk(s, 32'h0);
	endtask

	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		// reset values and an unmapped address
		rdchk(PDWD_OFS_PRESCALE, 32'hff, {24'h0, PDWD_PRESCALE_RST});
		// status is read-only: a write there must leave every bit as it was
		apb(1'b1, PDWD_OFS_STATUS, 32'hf);
		rdchk(PDWD_OFS_STATUS, 32'hf, 32'h0);
		apb(1'b0, 8'h0c, 32'h0);
		chk(err, 32'h1);
		// ratio 1:8 on the instruction clock times out in run
		apb(1'b1, PDWD_OFS_PRESCALE, 32'h3);
		ins(2'd1);
		wait_ev(4, 100);
		chk(n >= 24 && n <= 40, 32'h1);
		rdchk(PDWD_OFS_STATUS, 32'h3, 32'h2);
		rdchk(PDWD_OFS_PRESCALE, 32'hff, 32'h7);
		// asleep: deaf to masked pins and to a stopped watchdog
		ins(2'd0);
		rdchk(PDWD_OFS_STATUS, 32'hf, 32'h5);
		chk(osc_run, 32'h0);
		chk(core_hold, 32'h1);
		rdchk(PDWD_OFS_COUNT, 32'h7f, 32'h0);
		pins <= 8'hfd;
		quiet(600);
		pins <= 8'hfc;
		wait_ev(0, 1100);
		chk(n >= 1020 && n <= 1032, 32'h1);
		chk(core_hold, 32'h0);
		pins <= 8'hff;
		// clears: disabled watchdog, then the two-step pair
		cfg.wdt_enable <= 1'b0;
		ins(2'd1);
		rdchk(PDWD_OFS_STATUS, 32'h1, 32'h1);
		cfg <= '{1'b1, 1'b0, 1'b1, 8'h01};
		ins(2'd2);
		ins(2'd2);
		rdchk(PDWD_OFS_STATUS, 32'h1, 32'h1);
		ins(2'd3);
		rdchk(PDWD_OFS_STATUS, 32'h1, 32'h0);
		// a request pending at halt cannot wake; a masked one resumes
		cfg.two_clear <= 1'b0;
		int_req <= 4'h1;
		ins(2'd0);
		quiet(50);
		int_req <= 4'h3;
		wait_ev(0, 1100);
		chk(n >= 1020 && n <= 1032, 32'h1);
		ins(2'd1);
		rdchk(PDWD_OFS_STATUS, 32'h1, 32'h0);
		// enabled interrupt with room on the stack, then with a full stack
		int_req <= 4'h0;
		int_en <= 4'h4;
		ins(2'd0);
		int_req <= 4'h4;
		wait_ev(1, 1100);
		chk(n >= 1025 && n <= 1040, 32'h1);
		int_req <= 4'h0;
		stack_full <= 1'b1;
		ins(2'd0);
		int_req <= 4'h4;
		wait_ev(0, 1100);
		chk(n >= 1020 && n <= 1032, 32'h1);
		// source switched first so the run-mode count cannot trip at 1:1
		int_req <= 4'h0;
		stack_full <= 1'b0;
		cfg.src_osc <= 1'b1;
		apb(1'b1, PDWD_OFS_PRESCALE, 32'h0);
		ins(2'd0);
		tick_on <= 1'b1;
		wait_ev(2, 2000);
		chk(n >= 1520 && n <= 1560, 32'h1);
		tick_on <= 1'b0;
		rdchk(PDWD_OFS_STATUS, 32'h3, 32'h3);
		rdchk(PDWD_OFS_PRESCALE, 32'hff, 32'h0);
		// reset pin wakes with a full reset and reloads the prescaler
		ins(2'd0);
		ext_n <= 1'b0;
		@(posedge pclk);
		ext_n <= 1'b1;
		wait_ev(3, 1100);
		chk(n >= 1020 && n <= 1032, 32'h1);
		rdchk(PDWD_OFS_PRESCALE, 32'hff, 32'h7);
		finish_test();
	end
endmodule
